/* File: hdl/apirq_regs.sv */
// Purpose: wake-event latches, off-delay timer, interrupt routing and forced disk change
// Assumes: classic Wishbone slave, one clock, asynchronous active-low standby reset
// Notes:   pins pass three flip-flops; a level counts once stages two and three agree
//
// Behaviour
// - port one receive falling edge sets bit0
// - port two receive falling edge sets bit1
// - ring indication sets bit3, clear on read
// - button press sets bit2, not to power-on
// - off delay is (value+1) times 500 ms
// - start timer on button, enable and option
// - delay setting resets to zero
// - routing bit0 selects serial or parallel irqs
// - parallel mode: boot buffer off, pins irq15/14
// - routing bit2 puts sci on frame or pin
// - routing bit3 sets sci polarity
// - routing bit4 sets sci push-pull or open-drain
// - bits 6:5 pick pme, sci or irq9 pin
// - bit5 set overrides programmed sci irq number
// - shared pin driver follows selected function
// - routing bit7 puts smi on frame or pin
// - smi pin style configurable, default low open-drain
// - force bits set-only by software, reset 0x03
// - step with drive select clears force bit
// - disk change from selects, force bits, input
// - force bit shows change once drive selected
// - force bit0 drive0, bit1 drive1, upper zero
// - status bit one means event since clear
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module apirq_regs #(
  parameter int P_DELAY_UNIT_CYCLES = apirq_pkg::DELAY_UNIT_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [11:0] i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // pins
  input  wire logic        i_port_one_rx_wake,
  input  wire logic        i_port_two_rx_wake,
  input  wire logic        i_power_button_n,
  input  wire logic        i_ring_indicator_pin_n,
  input  wire logic        i_drive_step_signal_n,
  input  wire logic        i_drive_select_zero_n,
  input  wire logic        i_drive_select_one_n,
  input  wire logic        i_disk_change_input_n,
  // interrupt sources from the same clock domain, active high
  input  wire logic        i_sci_event,
  input  wire logic        i_smi_event,
  input  wire logic        i_pme_event,
  input  wire logic        i_irq9_event,
  input  wire logic        i_irq14_event,
  input  wire logic        i_irq15_event,
  // power control
  output logic             o_power_on_output_n,
  output logic             o_off_delay_done,
  output logic             o_off_delay_running,
  // interrupt routing
  output logic             o_serial_irq_mode,
  output logic             o_boot_buffer_enable,
  output logic             o_sci_irq_override,
  output logic             o_sci_frame_req,
  output logic             o_smi_frame_irq2_req,
  output logic             o_serial_irq_pin_o,
  output logic             o_serial_irq_pin_oe_n,
  output logic             o_bus_clock_pin_o,
  output logic             o_bus_clock_pin_oe_n,
  output logic             o_shared_pin_o,
  output logic             o_shared_pin_oe_n,
  output logic             o_dedicated_smi_pin_o,
  output logic             o_dedicated_smi_pin_oe_n,
  // floppy
  output logic             o_disk_change_bit
);

  localparam int NPIN = 8;

  // pin synchroniser and filtered levels
  logic [NPIN-1:0] sync1_reg;
  logic [NPIN-1:0] sync2_reg;
  logic [NPIN-1:0] sync3_reg;
  logic [NPIN-1:0] level_reg;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] fall;

  assign pin_raw = {i_disk_change_input_n, i_drive_select_one_n, i_drive_select_zero_n,
                    i_drive_step_signal_n, i_ring_indicator_pin_n, i_power_button_n,
                    i_port_two_rx_wake, i_port_one_rx_wake};

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
      sync3_reg <= '1;
      level_reg <= '1;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      level_reg <= (sync2_reg & sync3_reg) | (level_reg & (sync2_reg | sync3_reg));
    end
  end

  // a fall counts when the agreed level moves from high to low
  assign fall = level_reg & ~sync2_reg & ~sync3_reg;

  logic rx_one_fall;
  logic rx_two_fall;
  logic button_fall;
  logic ring_fall;
  logic step_act;
  logic ds0_act;
  logic ds1_act;
  logic dskchg_act;

  assign rx_one_fall = fall[0];
  assign rx_two_fall = fall[1];
  assign button_fall = fall[2];
  assign ring_fall   = fall[3];
  assign step_act    = ~level_reg[4];
  assign ds0_act     = ~level_reg[5];
  assign ds1_act     = ~level_reg[6];
  assign dskchg_act  = ~level_reg[7];

  // bus decode
  function automatic logic hit(input logic [11:0] adr, input logic [9:0] idx);
    hit = (adr[11:2] == idx);
  endfunction : hit

  logic access;
  logic wr_lane;
  logic rd_now;
  assign access  = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr_lane = access & i_wb_we & i_wb_sel[0];
  assign rd_now  = access & ~i_wb_we;

  logic                   wr_delay;
  logic                   wr_route;
  logic                   wr_disk;
  logic                   wr_ctrl;
  logic                   rd_status;
  assign wr_delay  = wr_lane & hit(i_wb_adr, apirq_pkg::IDX_DELAY_SET);
  assign wr_route  = wr_lane & hit(i_wb_adr, apirq_pkg::IDX_ROUTING);
  assign wr_disk   = wr_lane & hit(i_wb_adr, apirq_pkg::IDX_DISK_CHANGE);
  assign wr_ctrl   = wr_lane & hit(i_wb_adr, apirq_pkg::IDX_WAKE_CONTROL);
  assign rd_status = rd_now & hit(i_wb_adr, apirq_pkg::IDX_WAKE_STATUS);

  // registers
  logic [7:0]              wake_status_reg;
  logic [7:0]              delay_reg;
  apirq_pkg::apirq_route_t route_reg;
  logic [7:0]              disk_reg;
  logic [7:0]              ctrl_reg;
  logic [7:0]              wake_set;

  always_comb begin
    wake_set = 8'h00;
    wake_set[apirq_pkg::WAKE_RX_ONE] = rx_one_fall;
    wake_set[apirq_pkg::WAKE_RX_TWO] = rx_two_fall;
    wake_set[apirq_pkg::WAKE_BUTTON] = button_fall;
    wake_set[apirq_pkg::WAKE_RING]   = ring_fall;
  end

  // read clears, but an event in the same cycle survives
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wake_status_reg <= apirq_pkg::RST_WAKE_STATUS;
    end else if (rd_status) begin
      wake_status_reg <= wake_set;
    end else begin
      wake_status_reg <= wake_status_reg | wake_set;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      delay_reg <= apirq_pkg::RST_DELAY_SET;
    end else if (wr_delay) begin
      delay_reg <= i_wb_dat[7:0] & apirq_pkg::MSK_DELAY_SET;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      route_reg <= apirq_pkg::apirq_route_t'(apirq_pkg::RST_ROUTING);
    end else if (wr_route) begin
      route_reg <= apirq_pkg::apirq_route_t'(i_wb_dat[7:0] & apirq_pkg::MSK_ROUTING);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_reg <= apirq_pkg::RST_WAKE_CONTROL;
    end else if (wr_ctrl) begin
      ctrl_reg <= i_wb_dat[7:0] & apirq_pkg::MSK_WAKE_CONTROL;
    end
  end

  // force bits: software only sets, step with select clears, set wins
  logic [1:0] disk_clr;
  logic [1:0] disk_set;
  assign disk_clr = {step_act & ds1_act, step_act & ds0_act};
  assign disk_set = wr_disk ? i_wb_dat[1:0] : 2'h0;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      disk_reg <= apirq_pkg::RST_DISK_CHANGE;
    end else begin
      disk_reg <= {6'h00, (disk_reg[1:0] & ~disk_clr) | disk_set};
    end
  end

  // off-delay timer
  logic        running_reg;
  logic [31:0] prescale_reg;
  logic [5:0]  units_reg;
  logic [5:0]  target_reg;
  logic        unit_end;
  logic        timer_end;
  logic        timer_start;

  assign unit_end    = (prescale_reg == 32'(P_DELAY_UNIT_CYCLES - 1));
  assign timer_end   = running_reg & unit_end & (units_reg == target_reg);
  assign timer_start = button_fall & ctrl_reg[apirq_pkg::CTL_OFF_EN]
                     & ctrl_reg[apirq_pkg::CTL_DLY_OPT] & ~running_reg;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      running_reg  <= 1'b0;
      prescale_reg <= 32'h0000_0000;
      units_reg    <= 6'h00;
      target_reg   <= 6'h00;
    end else if (timer_start) begin
      running_reg  <= 1'b1;
      prescale_reg <= 32'h0000_0000;
      units_reg    <= 6'h00;
      target_reg   <= delay_reg[5:0];
    end else if (running_reg) begin
      if (timer_end) begin
        running_reg <= 1'b0;
      end
      if (unit_end) begin
        prescale_reg <= 32'h0000_0000;
        units_reg    <= units_reg + 6'h01;
      end else begin
        prescale_reg <= prescale_reg + 32'h0000_0001;
      end
    end
  end

  // power-on request: enabled wake events assert it, the off delay releases it
  logic power_on_reg;
  logic wake_on;
  assign wake_on = (rx_one_fall & ctrl_reg[apirq_pkg::WAKE_RX_ONE])
                 | (rx_two_fall & ctrl_reg[apirq_pkg::WAKE_RX_TWO])
                 | (ring_fall & ctrl_reg[apirq_pkg::WAKE_RING]);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      power_on_reg <= 1'b0;
    end else if (wake_on) begin
      power_on_reg <= 1'b1;
    end else if (timer_end) begin
      power_on_reg <= 1'b0;
    end
  end

  // shared pin, sci and smi drive
  logic                  parallel;
  logic                  sci_pin_level;
  apirq_pkg::apirq_pin_t shared_next;
  apirq_pkg::apirq_pin_t smi_next;
  logic                  smi_level;

  assign parallel      = route_reg.parallel_irq;
  assign sci_pin_level = route_reg.sci_active_high ? i_sci_event : ~i_sci_event;
  assign smi_level     = ctrl_reg[apirq_pkg::CTL_SMI_HIGH] ? i_smi_event : ~i_smi_event;

  always_comb begin
    shared_next = '{o: 1'b1, oe_n: 1'b1};
    case (route_reg.shared_sel)
      apirq_pkg::SHARED_PME: begin
        shared_next = '{o: 1'b0, oe_n: ~i_pme_event};
      end
      apirq_pkg::SHARED_SCI: begin
        if (!route_reg.sci_on_pin) begin
          shared_next = '{o: ~route_reg.sci_active_high, oe_n: route_reg.sci_open_drain};
        end else if (route_reg.sci_open_drain) begin
          shared_next = '{o: 1'b0, oe_n: sci_pin_level};
        end else begin
          shared_next = '{o: sci_pin_level, oe_n: 1'b0};
        end
      end
      apirq_pkg::SHARED_IRQ9: begin
        shared_next = '{o: i_irq9_event, oe_n: 1'b0};
      end
      default: begin
        shared_next = '{o: 1'b1, oe_n: 1'b1};
      end
    endcase
    if (!route_reg.smi_on_pin) begin
      smi_next = '{o: 1'b1, oe_n: 1'b1};
    end else if (ctrl_reg[apirq_pkg::CTL_SMI_PP]) begin
      smi_next = '{o: smi_level, oe_n: 1'b0};
    end else begin
      smi_next = '{o: 1'b0, oe_n: smi_level};
    end
  end

  // registered routing outputs
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_serial_irq_mode        <= 1'b1;
      o_boot_buffer_enable     <= 1'b1;
      o_sci_irq_override       <= 1'b0;
      o_sci_frame_req          <= 1'b0;
      o_smi_frame_irq2_req     <= 1'b0;
      o_serial_irq_pin_o       <= 1'b0;
      o_serial_irq_pin_oe_n    <= 1'b1;
      o_bus_clock_pin_o        <= 1'b0;
      o_bus_clock_pin_oe_n     <= 1'b1;
      o_shared_pin_o           <= 1'b1;
      o_shared_pin_oe_n        <= 1'b1;
      o_dedicated_smi_pin_o    <= 1'b1;
      o_dedicated_smi_pin_oe_n <= 1'b1;
    end else begin
      o_serial_irq_mode        <= ~parallel;
      o_boot_buffer_enable     <= ~parallel;
      o_sci_irq_override       <= route_reg.shared_sel[0];
      o_sci_frame_req          <= i_sci_event & ~route_reg.sci_on_pin;
      o_smi_frame_irq2_req     <= i_smi_event & ~route_reg.smi_on_pin;
      o_serial_irq_pin_o       <= i_irq15_event;
      o_serial_irq_pin_oe_n    <= ~parallel;
      o_bus_clock_pin_o        <= i_irq14_event;
      o_bus_clock_pin_oe_n     <= ~parallel;
      o_shared_pin_o           <= shared_next.o;
      o_shared_pin_oe_n        <= shared_next.oe_n;
      o_dedicated_smi_pin_o    <= smi_next.o;
      o_dedicated_smi_pin_oe_n <= smi_next.oe_n;
    end
  end

  // floppy and power outputs
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_disk_change_bit   <= 1'b0;
      o_power_on_output_n <= 1'b1;
      o_off_delay_done    <= 1'b0;
      o_off_delay_running <= 1'b0;
    end else begin
      o_disk_change_bit   <= (ds0_act & disk_reg[0]) | (ds1_act & disk_reg[1])
                           | dskchg_act;
      o_power_on_output_n <= ~power_on_reg;
      o_off_delay_done    <= timer_end;
      o_off_delay_running <= running_reg;
    end
  end

  // bus answer: one wait state, unmapped reads return zero
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit(i_wb_adr, apirq_pkg::IDX_WAKE_STATUS)) begin
      rd_byte = wake_status_reg & 8'h0f;
    end else if (hit(i_wb_adr, apirq_pkg::IDX_DELAY_SET)) begin
      rd_byte = delay_reg;
    end else if (hit(i_wb_adr, apirq_pkg::IDX_ROUTING)) begin
      rd_byte = route_reg;
    end else if (hit(i_wb_adr, apirq_pkg::IDX_DISK_CHANGE)) begin
      rd_byte = disk_reg;
    end else if (hit(i_wb_adr, apirq_pkg::IDX_WAKE_CONTROL)) begin
      rd_byte = ctrl_reg;
    end else if (hit(i_wb_adr, apirq_pkg::IDX_BLOCK_STATE)) begin
      rd_byte = {5'h00, o_disk_change_bit, power_on_reg, running_reg};
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= access;
      if (rd_now) begin
        o_wb_dat <= {24'h00_0000, rd_byte};
      end
    end
  end

endmodule : apirq_regs

`default_nettype wire

/* File: common/apirq_pkg.sv */
// Purpose: shared constants and types of the auxiliary power and interrupt routing registers
// Assumes: 100 MHz clock, registers one per 32-bit word at byte address four times the index
// Notes:   indices are kept as printed; byte address is index shifted left by two
package apirq_pkg;

  // register indices
  localparam logic [9:0] IDX_WAKE_STATUS  = 10'h0b3;
  localparam logic [9:0] IDX_DELAY_SET    = 10'h0b8;
  localparam logic [9:0] IDX_ROUTING      = 10'h0c0;
  localparam logic [9:0] IDX_DISK_CHANGE  = 10'h0c1;
  localparam logic [9:0] IDX_WAKE_CONTROL = 10'h0d0;
  localparam logic [9:0] IDX_BLOCK_STATE  = 10'h0d1;

  // reset values (asynchronous reset is the standby power-on reset)
  localparam logic [7:0] RST_WAKE_STATUS  = 8'h00;
  localparam logic [7:0] RST_DELAY_SET    = 8'h00;
  localparam logic [7:0] RST_ROUTING      = 8'h00;
  localparam logic [7:0] RST_DISK_CHANGE  = 8'h03;
  localparam logic [7:0] RST_WAKE_CONTROL = 8'h80;

  // writable bit masks
  localparam logic [7:0] MSK_DELAY_SET    = 8'h3f;
  localparam logic [7:0] MSK_ROUTING      = 8'hfd;
  localparam logic [7:0] MSK_DISK_CHANGE  = 8'h03;
  localparam logic [7:0] MSK_WAKE_CONTROL = 8'hfb;

  // wake status and wake control bit positions
  localparam int WAKE_RX_ONE  = 0;
  localparam int WAKE_RX_TWO  = 1;
  localparam int WAKE_BUTTON  = 2;
  localparam int WAKE_RING    = 3;
  localparam int CTL_DLY_OPT  = 4;
  localparam int CTL_SMI_HIGH = 5;
  localparam int CTL_SMI_PP   = 6;
  localparam int CTL_OFF_EN   = 7;

  // routing field values for the shared pin
  localparam logic [1:0] SHARED_PME  = 2'h0;
  localparam logic [1:0] SHARED_SCI  = 2'h1;
  localparam logic [1:0] SHARED_IRQ9 = 2'h2;

  // off-delay timing
  localparam int CLK_HZ            = 100_000_000;
  localparam int DELAY_UNIT_MS     = 500;
  localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_MS * (CLK_HZ / 1000);

  typedef struct packed {
    logic       smi_on_pin;
    logic [1:0] shared_sel;
    logic       sci_open_drain;
    logic       sci_active_high;
    logic       sci_on_pin;
    logic       reserved;
    logic       parallel_irq;
  } apirq_route_t;

  typedef struct packed {
    logic o;
    logic oe_n;
  } apirq_pin_t;

endpackage : apirq_pkg

/* File: tb/apirq_props.sv */
// Purpose: concurrent checks on the register block ports
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module apirq_props #(
  parameter int P_DELAY_UNIT_CYCLES = apirq_pkg::DELAY_UNIT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  input wire logic i_drive_select_zero_n,
  input wire logic i_drive_select_one_n,
  input wire logic i_disk_change_input_n,
  input wire logic i_sci_event,
  input wire logic i_smi_event,
  input wire logic o_off_delay_running,
  input wire logic o_serial_irq_mode,
  input wire logic o_boot_buffer_enable,
  input wire logic o_serial_irq_pin_oe_n,
  input wire logic o_bus_clock_pin_oe_n,
  input wire logic o_disk_change_bit,
  input wire logic o_sci_frame_req,
  input wire logic o_smi_frame_irq2_req
);
  localparam longint MAX_RUN = 64 * longint'(P_DELAY_UNIT_CYCLES) + 4;
  logic [31:0] run_cnt;
  // cycles the off-delay timer has been running
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) run_cnt <= 32'h0000_0000;
    else if (o_off_delay_running) run_cnt <= run_cnt + 32'h0000_0001;
    else run_cnt <= 32'h0000_0000;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_drives_idle;
    (i_drive_select_zero_n && i_drive_select_one_n && i_disk_change_input_n) [*7];
  endsequence
  sequence s_change_held;
    (!i_disk_change_input_n) [*7];
  endsequence
  property p_ack_pulse;    o_wb_ack |=> !o_wb_ack; endproperty
  property p_ack_answer;   (i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack; endproperty
  property p_boot_buf;     o_boot_buffer_enable == o_serial_irq_mode; endproperty
  property p_irq_pins;
    (o_serial_irq_pin_oe_n == o_serial_irq_mode) && (o_bus_clock_pin_oe_n == o_serial_irq_mode);
  endproperty
  property p_dsk_off;      s_drives_idle |-> !o_disk_change_bit; endproperty
  property p_dsk_on;       s_change_held |-> o_disk_change_bit; endproperty
  property p_sci_frame;    o_sci_frame_req |-> $past(i_sci_event); endproperty
  property p_smi_frame;    o_smi_frame_irq2_req |-> $past(i_smi_event); endproperty
  property p_delay_min;    $rose(o_off_delay_running) |=> o_off_delay_running [*8]; endproperty
  property p_delay_max;    o_off_delay_running |-> run_cnt < MAX_RUN; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_answer: assert property (p_ack_answer) else $error("request not acknowledged");
  a_boot_buf: assert property (p_boot_buf)
    else $error("boot buffer enable disagrees with irq mode");
  a_irq_pins: assert property (p_irq_pins)
    else $error("irq14 or irq15 pin drive disagrees with irq mode");
  a_dsk_off: assert property (p_dsk_off)
    else $error("disk change active with no drive selected");
  a_dsk_on: assert property (p_dsk_on)
    else $error("disk change input not passed on");
  a_sci_frame: assert property (p_sci_frame) else $error("sci frame without event");
  a_smi_frame: assert property (p_smi_frame) else $error("smi frame without event");
  a_delay_min: assert property (p_delay_min) else $error("off delay ended too soon");
  a_delay_max: assert property (p_delay_max) else $error("off delay runs too long");
endmodule : apirq_props
bind apirq_regs apirq_props #(.P_DELAY_UNIT_CYCLES(P_DELAY_UNIT_CYCLES)) u_props (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .o_wb_ack(o_wb_ack), .i_drive_select_zero_n(i_drive_select_zero_n),
  .i_drive_select_one_n(i_drive_select_one_n), .i_disk_change_input_n(i_disk_change_input_n),
  .i_sci_event(i_sci_event), .i_smi_event(i_smi_event),
  .o_off_delay_running(o_off_delay_running), .o_serial_irq_mode(o_serial_irq_mode),
  .o_boot_buffer_enable(o_boot_buffer_enable), .o_serial_irq_pin_oe_n(o_serial_irq_pin_oe_n),
  .o_bus_clock_pin_oe_n(o_bus_clock_pin_oe_n), .o_disk_change_bit(o_disk_change_bit),
  .o_sci_frame_req(o_sci_frame_req), .o_smi_frame_irq2_req(o_smi_frame_irq2_req)
);
`default_nettype wire

/* File: tb/apirq_host.sv */
// Purpose: host software model issuing classic wishbone cycles
// Assumes: slave answers every request with one ack
// Notes:   xfer is entered right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module apirq_host (
  input  wire logic        i_clk,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_dat,
  output logic             o_cyc,
  output logic             o_we,
  output logic      [11:0] o_adr,
  output logic      [31:0] o_dat
);
  initial begin
    o_cyc = 1'b0;
    o_we  = 1'b0;
    o_adr = 12'h000;
    o_dat = 32'h0000_0000;
  end
  task automatic xfer(input logic we, input logic [11:0] adr, input logic [7:0] wd,
                      output logic [31:0] rd);
    o_cyc <= 1'b1;
    o_we  <= we;
    o_adr <= adr;
    o_dat <= {24'h00_0000, wd};
    do begin
      @(posedge i_clk);
    end while (i_ack !== 1'b1);
    rd = i_dat;
    o_cyc <= 1'b0;
    o_we  <= 1'b0;
    // released data lines show no stale value
    o_dat <= ~o_dat;
    @(posedge i_clk);
  endtask : xfer
endmodule : apirq_host
`default_nettype wire

/* File: tb/aux_power_irq_config_regs_tb.sv */
// Purpose: self-checking bench of the auxiliary power and routing registers
// Assumes: off-delay unit shortened to 20 cycles
// Notes:   one task per scenario, the host model issues bus cycles
`timescale 1ns/1ps
`default_nettype none
module aux_power_irq_config_regs_tb;
  localparam int UNIT = 20;
  logic        clk, resetn, cyc, we, ack;
  logic [11:0] adr;
  logic [31:0] wdat, rdat, rd;
  logic [3:0]  wake_n, fd_n;
  logic [5:0]  ev;
  logic        done, running, ser_mode, boot_en, override, sci_f, smi_f, dchg, pwr_n;
  logic        s15_o, s15_oe_n, c14_o, c14_oe_n, sh_o, sh_oe_n, smi_o, smi_oe_n;
  int          error_cnt, check_count, cyc_cnt;
  apirq_regs #(.P_DELAY_UNIT_CYCLES(UNIT)) dut (
    .i_clk(clk), .i_resetn(resetn), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_port_one_rx_wake(wake_n[0]), .i_port_two_rx_wake(wake_n[1]),
    .i_power_button_n(wake_n[2]), .i_ring_indicator_pin_n(wake_n[3]),
    .i_drive_step_signal_n(fd_n[0]), .i_drive_select_zero_n(fd_n[1]),
    .i_drive_select_one_n(fd_n[2]), .i_disk_change_input_n(fd_n[3]),
    .i_sci_event(ev[0]), .i_smi_event(ev[1]), .i_pme_event(ev[2]), .i_irq9_event(ev[3]),
    .i_irq14_event(ev[4]), .i_irq15_event(ev[5]), .o_power_on_output_n(pwr_n),
    .o_off_delay_done(done), .o_off_delay_running(running), .o_serial_irq_mode(ser_mode),
    .o_boot_buffer_enable(boot_en), .o_sci_irq_override(override), .o_sci_frame_req(sci_f),
    .o_smi_frame_irq2_req(smi_f), .o_serial_irq_pin_o(s15_o), .o_serial_irq_pin_oe_n(s15_oe_n),
    .o_bus_clock_pin_o(c14_o), .o_bus_clock_pin_oe_n(c14_oe_n), .o_shared_pin_o(sh_o),
    .o_shared_pin_oe_n(sh_oe_n), .o_dedicated_smi_pin_o(smi_o),
    .o_dedicated_smi_pin_oe_n(smi_oe_n), .o_disk_change_bit(dchg));
  apirq_host host (.i_clk(clk), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc), .o_we(we),
                   .o_adr(adr), .o_dat(wdat));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, rd);
  endtask : wr
  task automatic rdc(input string nm, input logic [11:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 8'h00, rd);
    chk(nm, rd, {24'h00_0000, e});
  endtask : rdc
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic t_reset;
    logic [11:0] a [6] = '{12'h2cc, 12'h2e0, 12'h300, 12'h304, 12'h340, 12'h3fc};
    logic [7:0]  e [6] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h80, 8'h00};
    for (int i = 0; i < 6; i++) begin
      rdc("reset value", a[i], e[i]);
    end
    chk("serial mode", ser_mode, 1'b1);
    wr(12'h2e0, 8'hff);
    rdc("delay mask", 12'h2e0, 8'h3f);
    wr(12'h3fc, 8'h5a);
    rdc("unmapped", 12'h3fc, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_wake;
    for (int i = 0; i < 4; i++) begin
      wake_n <= ~(4'h1 << i);
      tick(8);
      wake_n <= 4'hf;
      tick(8);
      rdc("wake status", 12'h2cc, 8'h01 << i);
    end
    rdc("status cleared", 12'h2cc, 8'h00);
    chk("timer idle", running, 1'b0);
    $display("test wake done");
  endtask : t_wake
  task automatic t_disk;
    fd_n <= 4'hd;
    tick(8);
    chk("forced change drive0", dchg, 1'b1);
    fd_n <= 4'hc;
    tick(8);
    fd_n <= 4'hf;
    tick(8);
    chk("change idle", dchg, 1'b0);
    rdc("step clears bit0", 12'h304, 8'h02);
    wr(12'h304, 8'h00);
    rdc("no software clear", 12'h304, 8'h02);
    fd_n <= 4'ha;
    tick(8);
    fd_n <= 4'hd;
    tick(8);
    chk("drive0 cleared", dchg, 1'b0);
    rdc("step clears bit1", 12'h304, 8'h00);
    wr(12'h304, 8'hfd);
    rdc("software set", 12'h304, 8'h01);
    tick(6);
    chk("set shows once selected", dchg, 1'b1);
    fd_n <= 4'h7;
    tick(8);
    chk("external change", dchg, 1'b1);
    fd_n <= 4'hf;
    $display("test disk done");
  endtask : t_disk
  task automatic t_delay;
    logic [7:0] code [2] = '{8'h00, 8'h3f};
    int n;
    int exp;
    wr(12'h340, 8'h98);
    wake_n <= 4'h7;
    tick(8);
    chk("power on", pwr_n, 1'b0);
    wake_n <= 4'hf;
    for (int i = 0; i < 2; i++) begin
      wr(12'h2e0, code[i]);
      exp = (int'(code[i]) + 1) * UNIT;
      wake_n <= 4'hb;
      n = 0;
      do begin
        tick(1);
        n++;
      end while (done !== 1'b1 && n < 2000);
      chk("delay window", (n >= exp) && (n <= exp + 10), 1'b1);
      wake_n <= 4'hf;
      tick(8);
    end
    chk("power released", pwr_n, 1'b1);
    wr(12'h340, 8'h80);
    wake_n <= 4'hb;
    tick(12);
    chk("no start without option", running, 1'b0);
    wake_n <= 4'hf;
    rdc("button latched", 12'h2cc, 8'h0c);
    $display("test delay done");
  endtask : t_delay
  task automatic t_route;
    logic [11:0] rt [7] = '{12'h00c, 12'h840, 12'h248, 12'h2c9, 12'h348, 12'h40d, 12'h60e};
    logic [11:0] t;
    for (int i = 0; i < 7; i++) begin
      t = rt[i];
      wr(12'h300, t[11:4]);
      tick(2);
      chk("smi frame", smi_f, t[3]);
      chk("sci frame", sci_f, t[2]);
      chk("shared pin", {sh_oe_n, sh_o & ~sh_oe_n}, {t[1], t[0] & ~t[1]});
      chk("smi pin", {smi_oe_n, smi_o & ~smi_oe_n}, {~t[11], 1'b0});
      chk("override", override, t[9]);
      chk("serial mode kept", ser_mode, 1'b1);
    end
    wr(12'h300, 8'h80);
    wr(12'h340, 8'he0);
    tick(2);
    chk("smi high push-pull", {smi_oe_n, smi_o}, 2'h1);
    wr(12'h300, 8'h00);
    ev <= 6'h00;
    tick(3);
    chk("pme idle", sh_oe_n, 1'b1);
    chk("smi idle", smi_f, 1'b0);
    ev <= 6'h2f;
    wr(12'h300, 8'hff);
    rdc("routing mask", 12'h300, 8'hfd);
    chk("parallel pins", {boot_en, ser_mode, s15_oe_n, s15_o, c14_oe_n, c14_o}, 6'h04);
    wr(12'h300, 8'h00);
    tick(2);
    chk("serial pins", {s15_oe_n, c14_oe_n}, 2'h3);
    $display("test route done");
  endtask : t_route
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    resetn = 1'b0;
    wake_n = 4'hf;
    fd_n = 4'hf;
    ev = 6'h2f;
    error_cnt = 0;
    check_count = 0;
    cyc_cnt = 0;
    tick(16);
    resetn <= 1'b1;
    tick(5);
    t_reset();
    t_wake();
    t_disk();
    t_delay();
    t_route();
    resetn <= 1'b0;
    tick(3);
    resetn <= 1'b1;
    tick(5);
    t_reset();
    stop_test();
  end
endmodule : aux_power_irq_config_regs_tb
`default_nettype wire
